// File: exio_pkg.sv
// exio_pkg: register map, field positions and timing constants
// assumes a 100 MHz clock and a 12-bit axi4-lite byte address
package exio_pkg;
	localparam int N_INST      = 3;
	localparam int N_CH        = 13;
	localparam int N_PIN       = 11;
	localparam int N_SLOT      = 10;
	localparam int CH_FAST_IN  = 9;
	localparam int CH_FAST_OUT = 11;
	localparam int P_FAST      = 6;
	localparam int P_PRES      = 8;
	localparam int CLK_NS      = 10;
	localparam int TICK_NS     = 1000;
	localparam int TICK_CYC    = TICK_NS / CLK_NS;
	localparam int CFG_POL     = 8;
	localparam logic [11:0] A_SLOT    = 12'h000;
	localparam logic [11:0] A_DIR     = 12'h010;
	localparam logic [11:0] A_ONLINE  = 12'h020;
	localparam logic [11:0] A_PHYS    = 12'h024;
	localparam logic [11:0] A_AOUT_SRC  = 12'h028;
	localparam logic [11:0] A_AOUT_FILT = 12'h02C;
	localparam logic [11:0] A_AOUT_LO   = 12'h030;
	localparam logic [11:0] A_AOUT_LOR  = 12'h034;
	localparam logic [11:0] A_AOUT_HI   = 12'h038;
	localparam logic [11:0] A_AOUT_HIR  = 12'h03C;
	localparam logic [11:0] A_CH      = 12'h100;
	localparam logic [3:0]  CH_CFG    = 4'h0;
	localparam logic [3:0]  CH_ON     = 4'h4;
	localparam logic [3:0]  CH_OFF    = 4'h8;
	localparam logic [3:0]  SLOT_OFF  = 4'h0;
	localparam logic [3:0]  SLOT_MAX  = 4'hA;
	localparam logic [4:0]  AOUT_RSV_A   = 5'h0E;
	localparam logic [4:0]  AOUT_RSV_B   = 5'h0F;
	localparam logic [4:0]  AOUT_SRC_MAX = 5'h13;
	localparam logic [15:0] AOUT_HI_RST  = 16'hFFFF;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// File: exio_cond.sv
// exio_cond: on-delay, off-delay and polarity stage for one terminal
// assumes a one-cycle time base tick and a synchronous raw level
`timescale 1ns/1ps
module exio_cond (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_tick,
	// level and settings
	input  wire logic        i_in,
	input  wire logic        i_pol,
	input  wire logic [15:0] i_on,
	input  wire logic [15:0] i_off,
	// conditioned level
	output logic             o_level
);
	typedef struct packed {
		logic        a;
		logic        b;
		logic        lvl;
		logic [15:0] con;
		logic [15:0] coff;
	} exio_cond_type;

	exio_cond_type r_ff, nxt_r;

	always_comb begin
		nxt_r = r_ff;
		// on-delay: rise only after i_on ticks high
		if (!i_in) begin
			nxt_r.a = 1'b0;
			nxt_r.con = 16'h0000;
		end else if (!r_ff.a) begin
			if (r_ff.con >= i_on)
				nxt_r.a = 1'b1;
			else if (i_tick)
				nxt_r.con = r_ff.con + 16'h0001;
		end
		// off-delay follows the on-delay stage
		if (r_ff.a) begin
			nxt_r.b = 1'b1;
			nxt_r.coff = 16'h0000;
		end else if (r_ff.b) begin
			if (r_ff.coff >= i_off)
				nxt_r.b = 1'b0;
			else if (i_tick)
				nxt_r.coff = r_ff.coff + 16'h0001;
		end
		nxt_r.lvl = r_ff.b ^ i_pol;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign o_level = r_ff.lvl;

	property p_on_drop;
		@(posedge i_clk) disable iff (!i_rst_n)
		!i_in |=> !r_ff.a;
	endproperty
	a_on_drop: assert property (p_on_drop)
		else $error("on-delay stage did not drop");

	sequence s_a_high;
		r_ff.a;
	endsequence
	property p_off_rise;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_a_high |=> r_ff.b;
	endproperty
	a_off_rise: assert property (p_off_rise)
		else $error("off-delay stage missed a rise");

	property p_pol;
		@(posedge i_clk) disable iff (!i_rst_n)
		r_ff.b |=> (o_level != $past(i_pol));
	endproperty
	a_pol: assert property (p_pol)
		else $error("polarity not applied");
endmodule

// File: exio_aout.sv
// exio_aout: limit scaling and smoothing for analog output two
// assumes unsigned 16-bit codes and a one-cycle time base tick
`timescale 1ns/1ps
module exio_aout (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_tick,
	// selected value and settings
	input  wire logic [15:0] i_val,
	input  wire logic [15:0] i_lo,
	input  wire logic [15:0] i_lor,
	input  wire logic [15:0] i_hi,
	input  wire logic [15:0] i_hir,
	input  wire logic [3:0]  i_shift,
	// output code
	output logic [15:0]      o_value
);
	typedef struct packed {
		logic [15:0] scaled;
		logic [31:0] acc;
	} exio_aout_type;

	exio_aout_type r_ff, nxt_r;

	always_comb begin
		logic [15:0]        x;
		logic signed [33:0] num;
		logic signed [33:0] q;
		logic signed [32:0] err;
		logic signed [32:0] d;
		nxt_r = r_ff;
		x = i_val;
		num = '0;
		q = '0;
		err = '0;
		d = '0;
		// clamp to the limits, then map onto the ratio span
		if (x < i_lo)
			x = i_lo;
		if (x > i_hi)
			x = i_hi;
		if (i_hi <= i_lo) begin
			nxt_r.scaled = i_lor;
		end else begin
			num = 34'($signed({1'b0, x - i_lo}) *
				($signed({1'b0, i_hir}) - $signed({1'b0, i_lor})));
			q = num / 34'($signed({1'b0, i_hi - i_lo}));
			nxt_r.scaled = i_lor + q[15:0];
		end
		// first-order filter, time constant 2^shift ticks
		err = $signed({1'b0, r_ff.scaled, 16'h0000}) -
			$signed({1'b0, r_ff.acc});
		d = err >>> i_shift;
		if (i_tick)
			nxt_r.acc = r_ff.acc + d[31:0];
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign o_value = r_ff.acc[31:16];

	property p_clamp;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_hi > i_lo && i_val >= i_hi) |=> (r_ff.scaled == $past(i_hir));
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("upper limit not mapped to its ratio");

	property p_filter;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_tick && i_shift == 4'h0) |=> (o_value == $past(r_ff.scaled));
	endproperty
	a_filter: assert property (p_filter)
		else $error("filter with zero shift did not follow");
endmodule

// File: exio_top.sv
// exio_top: expansion io configuration, terminal conditioning, aout2
// assumes an axi4-lite master on I_MCLK and asynchronous field pins
`timescale 1ns/1ps

module exio_top (
	// clock and reset
	input  wire logic         I_MCLK,
	input  wire logic         I_RST_N,
	// axi4-lite write
	input  wire logic         I_AWVALID,
	output logic              O_AWREADY,
	input  wire logic [11:0]  I_AWADDR,
	input  wire logic         I_WVALID,
	output logic              O_WREADY,
	input  wire logic [31:0]  I_WDATA,
	input  wire logic [3:0]   I_WSTRB,
	output logic              O_BVALID,
	input  wire logic         I_BREADY,
	output logic [1:0]        O_BRESP,
	// axi4-lite read
	input  wire logic         I_ARVALID,
	output logic              O_ARREADY,
	input  wire logic [11:0]  I_ARADDR,
	output logic              O_RVALID,
	input  wire logic         I_RREADY,
	output logic [31:0]       O_RDATA,
	output logic [1:0]        O_RRESP,
	// internal signals and aout2 quantities
	input  wire logic [31:0]  I_INT_SIG,
	input  wire logic [319:0] I_AOUT_QTY,
	// field pins
	input  wire logic [2:0]   I_MOD_PRESENT,
	input  wire logic [5:0]   I_BIDIR_IN,
	output logic [5:0]        O_BIDIR_OUT,
	output logic [5:0]        O_BIDIR_OE,
	output logic [2:0]        O_RELAY,
	input  wire logic [1:0]   I_FAST_IN,
	output logic [1:0]        O_FAST_OUT,
	// conditioned inputs, slot decode, aout2
	output logic [7:0]        O_DIN,
	output logic [29:0]       O_SLOT_HOT,
	output logic [15:0]       O_AOUT2
);
	localparam int NI = exio_pkg::N_INST;
	localparam int NC = exio_pkg::N_CH;
	localparam int NP = exio_pkg::N_PIN;

	typedef struct packed {
		logic [NI-1:0][3:0]  slot;
		logic [NI-1:0][1:0]  dir;
		logic [NC-1:0][8:0]  cfg;
		logic [NC-1:0][15:0] on_dly;
		logic [NC-1:0][15:0] off_dly;
		logic [4:0]          aout_src;
		logic [3:0]          aout_filt;
		logic [15:0]         aout_lo;
		logic [15:0]         aout_lor;
		logic [15:0]         aout_hi;
		logic [15:0]         aout_hir;
		logic [15:0]         aout_sel;
		logic [NP-1:0]       s1;
		logic [NP-1:0]       s2;
		logic [NP-1:0]       s3;
		logic [NP-1:0]       pin;
		logic [6:0]          tick_cnt;
		logic                tick;
		logic                aw_got;
		logic [11:0]         awaddr;
		logic                w_got;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} exio_state_type;

	exio_state_type r_ff, nxt_r;
	logic [1:0]    rst_q_ff;
	logic          rst_n;
	logic [NI-1:0] en;
	logic [NC-1:0] raw;
	logic [NC-1:0] lvl;

	// release of the asynchronous reset is retimed to the clock
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N)
			rst_q_ff <= 2'h0;
		else
			rst_q_ff <= {rst_q_ff[0], 1'b1};
	end
	assign rst_n = rst_q_ff[1];

	// register read view; bit 32 flags a mapped address
	function automatic logic [32:0] rd_word(
		input exio_state_type s,
		input logic [11:0]    a,
		input logic [NI-1:0]  e
	);
		logic [3:0]  c;
		logic [32:0] v;
		c = a[7:4];
		v = {1'b0, 32'h0000_0000};
		if (a[11:4] == exio_pkg::A_SLOT[11:4] && a[3:2] < 2'(NI))
			v = {1'b1, 28'h000_0000, s.slot[a[3:2]]};
		else if (a[11:4] == exio_pkg::A_DIR[11:4] && a[3:2] < 2'(NI))
			v = {1'b1, 30'h0000_0000, s.dir[a[3:2]]};
		else if (a[11:8] == exio_pkg::A_CH[11:8] && c < 4'(NC)) begin
			case (a[3:0])
				exio_pkg::CH_CFG: v = {1'b1, 23'h00_0000, s.cfg[c]};
				exio_pkg::CH_ON:  v = {1'b1, 16'h0000, s.on_dly[c]};
				exio_pkg::CH_OFF: v = {1'b1, 16'h0000, s.off_dly[c]};
				default:          v = {1'b0, 32'h0000_0000};
			endcase
		end else begin
			case (a)
				exio_pkg::A_ONLINE:
					v = {1'b1, 29'h0, e & s.pin[exio_pkg::P_PRES +: NI]};
				exio_pkg::A_PHYS:
					v = {1'b1, 26'h0, s.pin[5:0]};
				exio_pkg::A_AOUT_SRC:  v = {1'b1, 27'h0, s.aout_src};
				exio_pkg::A_AOUT_FILT: v = {1'b1, 28'h0, s.aout_filt};
				exio_pkg::A_AOUT_LO:   v = {1'b1, 16'h0, s.aout_lo};
				exio_pkg::A_AOUT_LOR:  v = {1'b1, 16'h0, s.aout_lor};
				exio_pkg::A_AOUT_HI:   v = {1'b1, 16'h0, s.aout_hi};
				exio_pkg::A_AOUT_HIR:  v = {1'b1, 16'h0, s.aout_hir};
				default:             v = {1'b0, 32'h0000_0000};
			endcase
		end
		return v;
	endfunction

	always_comb begin
		logic [32:0] old;
		logic [32:0] rv;
		logic [31:0] m;
		logic [11:0] wa;
		logic [3:0]  c;
		nxt_r = r_ff;
		old = '0;
		rv = '0;
		m = '0;
		wa = r_ff.awaddr;
		c = wa[7:4];

		// three stages; a change counts once stages two and three agree
		nxt_r.s1 = {I_MOD_PRESENT, I_FAST_IN, I_BIDIR_IN};
		nxt_r.s2 = r_ff.s1;
		nxt_r.s3 = r_ff.s2;
		nxt_r.pin = (r_ff.s2 & r_ff.s3) | (r_ff.pin & (r_ff.s2 | r_ff.s3));

		// 1 us time base for all delay counters
		nxt_r.tick = 1'b0;
		if (r_ff.tick_cnt == 7'(exio_pkg::TICK_CYC - 1)) begin
			nxt_r.tick_cnt = 7'h00;
			nxt_r.tick = 1'b1;
		end else begin
			nxt_r.tick_cnt = r_ff.tick_cnt + 7'h01;
		end

		// reserved or out-of-range sources give zero
		if (r_ff.aout_src == exio_pkg::AOUT_RSV_A ||
			r_ff.aout_src == exio_pkg::AOUT_RSV_B ||
			r_ff.aout_src > exio_pkg::AOUT_SRC_MAX)
			nxt_r.aout_sel = 16'h0000;
		else
			nxt_r.aout_sel =
				I_AOUT_QTY[{r_ff.aout_src, 4'h0} +: 16];

		// write address and data are taken in either order
		if (I_AWVALID && O_AWREADY) begin
			nxt_r.aw_got = 1'b1;
			nxt_r.awaddr = I_AWADDR;
		end
		if (I_WVALID && O_WREADY) begin
			nxt_r.w_got = 1'b1;
			nxt_r.wdata = I_WDATA;
			nxt_r.wstrb = I_WSTRB;
		end
		if (r_ff.bvalid && I_BREADY)
			nxt_r.bvalid = 1'b0;
		if (r_ff.aw_got && r_ff.w_got) begin
			old = rd_word(r_ff, wa, en);
			for (int b = 0; b < 4; b++)
				m[8*b +: 8] = r_ff.wstrb[b] ? r_ff.wdata[8*b +: 8] :
					old[8*b +: 8];
			nxt_r.aw_got = 1'b0;
			nxt_r.w_got = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp = old[32] ? exio_pkg::RESP_OKAY :
				exio_pkg::RESP_SLVERR;
			if (old[32]) begin
				if (wa[11:4] == exio_pkg::A_SLOT[11:4])
					nxt_r.slot[wa[3:2]] = m[3:0];
				else if (wa[11:4] == exio_pkg::A_DIR[11:4])
					nxt_r.dir[wa[3:2]] = m[1:0];
				else if (wa[11:8] == exio_pkg::A_CH[11:8]) begin
					case (wa[3:0])
						exio_pkg::CH_CFG: nxt_r.cfg[c] = m[8:0];
						exio_pkg::CH_ON:  nxt_r.on_dly[c] = m[15:0];
						exio_pkg::CH_OFF: nxt_r.off_dly[c] = m[15:0];
						default:          nxt_r.cfg[c] = r_ff.cfg[c];
					endcase
				end else begin
					// status words ignore writes
					case (wa)
						exio_pkg::A_AOUT_SRC:  nxt_r.aout_src = m[4:0];
						exio_pkg::A_AOUT_FILT: nxt_r.aout_filt = m[3:0];
						exio_pkg::A_AOUT_LO:   nxt_r.aout_lo = m[15:0];
						exio_pkg::A_AOUT_LOR:  nxt_r.aout_lor = m[15:0];
						exio_pkg::A_AOUT_HI:   nxt_r.aout_hi = m[15:0];
						exio_pkg::A_AOUT_HIR:  nxt_r.aout_hir = m[15:0];
						default: nxt_r.aout_src = r_ff.aout_src;
					endcase
				end
			end
		end

		// read: one cycle to rvalid, held until rready
		if (r_ff.rvalid && I_RREADY)
			nxt_r.rvalid = 1'b0;
		if (I_ARVALID && O_ARREADY) begin
			rv = rd_word(r_ff, I_ARADDR, en);
			nxt_r.rvalid = 1'b1;
			nxt_r.rdata = rv[31:0];
			nxt_r.rresp = rv[32] ? exio_pkg::RESP_OKAY :
				exio_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge I_MCLK or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '0;
			r_ff.aout_hi <= exio_pkg::AOUT_HI_RST;
			r_ff.aout_hir <= exio_pkg::AOUT_HI_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// per expansion instance: slot decode and pin drive
	for (genvar i = 0; i < NI; i++) begin : g_inst
		assign en[i] = r_ff.slot[i] != exio_pkg::SLOT_OFF &&
			r_ff.slot[i] <= exio_pkg::SLOT_MAX;
		for (genvar s = 1; s <= exio_pkg::N_SLOT; s++) begin : g_slot
			assign O_SLOT_HOT[exio_pkg::N_SLOT*i + s - 1] =
				r_ff.slot[i] == 4'(s);
		end
		for (genvar k = 0; k < 2; k++) begin : g_term
			assign O_BIDIR_OUT[2*i + k] = lvl[3*i + k];
			// pin is driven only in output mode on an enabled module
			assign O_BIDIR_OE[2*i + k] = en[i] & r_ff.dir[i][k];
			assign O_DIN[2*i + k] = lvl[3*i + k];
		end
		assign O_RELAY[i] = en[i] & lvl[3*i + 2];
	end

	// channel k of instance i: 3*i+k, relay third; then fast in/out
	for (genvar ch = 0; ch < NC; ch++) begin : g_ch
		if (ch < exio_pkg::CH_FAST_IN) begin : g_x
			localparam int I = ch / 3;
			localparam int K = ch % 3;
			if (K == 2) begin : g_rly
				assign raw[ch] = en[I] & I_INT_SIG[r_ff.cfg[ch][4:0]];
			end else begin : g_dio
				assign raw[ch] = r_ff.dir[I][K] ?
					en[I] & I_INT_SIG[r_ff.cfg[ch][4:0]] :
					r_ff.pin[2*I + K];
			end
		end else if (ch < exio_pkg::CH_FAST_OUT) begin : g_fi
			assign raw[ch] =
				r_ff.pin[exio_pkg::P_FAST + ch - exio_pkg::CH_FAST_IN];
		end else begin : g_fo
			assign raw[ch] = I_INT_SIG[r_ff.cfg[ch][4:0]];
		end
		exio_cond u_cond (
			.i_clk   (I_MCLK),
			.i_rst_n (rst_n),
			.i_tick  (r_ff.tick),
			.i_in    (raw[ch]),
			.i_pol   (r_ff.cfg[ch][exio_pkg::CFG_POL]),
			.i_on    (r_ff.on_dly[ch]),
			.i_off   (r_ff.off_dly[ch]),
			.o_level (lvl[ch])
		);
	end

	assign O_DIN[7:6] = lvl[exio_pkg::CH_FAST_IN +: 2];
	assign O_FAST_OUT = lvl[exio_pkg::CH_FAST_OUT +: 2];

	exio_aout u_aout (
		.i_clk   (I_MCLK),
		.i_rst_n (rst_n),
		.i_tick  (r_ff.tick),
		.i_val   (r_ff.aout_sel),
		.i_lo    (r_ff.aout_lo),
		.i_lor   (r_ff.aout_lor),
		.i_hi    (r_ff.aout_hi),
		.i_hir   (r_ff.aout_hir),
		.i_shift (r_ff.aout_filt),
		.o_value (O_AOUT2)
	);

	// handshake readies stall while a response is pending
	assign O_AWREADY = !r_ff.aw_got && !r_ff.bvalid;
	assign O_WREADY  = !r_ff.w_got && !r_ff.bvalid;
	assign O_BVALID  = r_ff.bvalid;
	assign O_BRESP   = r_ff.bresp;
	assign O_ARREADY = !r_ff.rvalid;
	assign O_RVALID  = r_ff.rvalid;
	assign O_RDATA   = r_ff.rdata;
	assign O_RRESP   = r_ff.rresp;

	property p_slot_top;
		@(posedge I_MCLK) disable iff (!rst_n)
		(r_ff.slot[0] == exio_pkg::SLOT_MAX) |->
			(O_SLOT_HOT[9:0] == 10'h200 && en[0]);
	endproperty
	a_slot_top: assert property (p_slot_top)
		else $error("slot code 10 not decoded");

	property p_slot_off;
		@(posedge I_MCLK) disable iff (!rst_n)
		(r_ff.slot[1] == exio_pkg::SLOT_OFF) |->
			(O_SLOT_HOT[19:10] == 10'h000 && O_BIDIR_OE[3:2] == 2'h0);
	endproperty
	a_slot_off: assert property (p_slot_off)
		else $error("disabled module still drives");

	sequence s_dir_wr;
		r_ff.aw_got && r_ff.w_got && r_ff.awaddr == exio_pkg::A_DIR &&
			r_ff.wstrb[0] && r_ff.wdata[0] && en[0];
	endsequence
	property p_dir_oe;
		@(posedge I_MCLK) disable iff (!rst_n)
		s_dir_wr |=> O_BIDIR_OE[0];
	endproperty
	a_dir_oe: assert property (p_dir_oe)
		else $error("direction write did not enable output");

	sequence s_both;
		r_ff.aw_got && r_ff.w_got;
	endsequence
	property p_bresp;
		@(posedge I_MCLK) disable iff (!rst_n)
		s_both |=> (O_BVALID && !O_AWREADY && !O_WREADY);
	endproperty
	a_bresp: assert property (p_bresp)
		else $error("write response missing");

	property p_rsvd;
		@(posedge I_MCLK) disable iff (!rst_n)
		(r_ff.aout_src == exio_pkg::AOUT_RSV_B) |=>
			(r_ff.aout_sel == 16'h0000);
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved aout source not zero");
endmodule

// File: exio_field.sv
// exio_field: field wiring seen by the bidirectional terminal pins
// assumes pins driven by the block win over outside drivers
`timescale 1ns/1ps
module exio_field (
	// clock
	input  wire logic       i_clk,
	// block side
	input  wire logic [5:0] i_drive,
	input  wire logic [5:0] i_oe,
	// outside drivers
	input  wire logic [5:0] i_ext,
	input  wire logic [5:0] i_ext_en,
	// resolved pin levels
	output logic [5:0]      o_pin
);
	logic [5:0] alt_ff = 6'h15;

	// a floating pin toggles every clock, so the input filter keeps its last level
	always_ff @(posedge i_clk) begin
		alt_ff <= ~alt_ff;
	end

	assign o_pin = (i_oe & i_drive) | (~i_oe & i_ext_en & i_ext)
		| (~i_oe & ~i_ext_en & alt_ff);
endmodule

// File: expansion_io_config_bench.sv
// expansion_io_config_bench: self-checking bench for exio_top
// assumes exio_field stands for the wiring on the bidir pins
`timescale 1ns/1ps
module expansion_io_config_bench;
	typedef struct packed {
		logic [31:0] d;
		logic [1:0]  r;
	} exio_rd_type;
	logic         clk = 1'b0, rst_n = 1'b0;
	logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic         arvalid = 1'b0, rready = 1'b0;
	logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
	logic [31:0]  wdata = 32'h0, sig = 32'h0;
	logic [319:0] qty = '0;
	logic [5:0]   ext = 6'h00, ext_en = 6'h06;
	logic [2:0]   pres = 3'h0;
	logic [1:0]   fin = 2'h0;
	logic         awready, wready, bvalid, arready, rvalid;
	logic [1:0]   bresp, rresp, fout;
	logic [31:0]  rdata;
	logic [5:0]   bout, boe, bin;
	logic [2:0]   relay;
	logic [7:0]   din;
	logic [29:0]  hot;
	logic [15:0]  aout;
	logic [24:0]  obs;
	int           n_mismatch = 0, n_checks = 0, seed = 33475, c;
	exio_rd_type  rq[$];
	exio_rd_type  re;
	assign obs = {fout, din, relay, boe, bout};
	always #5 clk = ~clk;

	exio_top DUT (.I_MCLK(clk), .I_RST_N(rst_n),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
		.I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
		.I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready),
		.O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
		.O_RDATA(rdata), .O_RRESP(rresp), .I_INT_SIG(sig),
		.I_AOUT_QTY(qty), .I_MOD_PRESENT(pres), .I_BIDIR_IN(bin),
		.O_BIDIR_OUT(bout), .O_BIDIR_OE(boe), .O_RELAY(relay),
		.I_FAST_IN(fin), .O_FAST_OUT(fout), .O_DIN(din),
		.O_SLOT_HOT(hot), .O_AOUT2(aout));
	exio_field field (.i_clk(clk), .i_drive(bout), .i_oe(boe),
		.i_ext(ext), .i_ext_en(ext_en), .o_pin(bin));

	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [11:0] cha(input int ch, input logic [3:0] o);
		return exio_pkg::A_CH + 12'(ch * 16) + {8'h00, o};
	endfunction
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && t < 100);
		bready <= 1'b0;
		if (t >= 100) check("bvalid", 32'h0, 32'h1);
		// only the unused word at 0x0FC is unmapped in this bench
		check("bresp", {30'h0, bresp}, {30'h0, (a == 12'h0FC) ?
			exio_pkg::RESP_SLVERR : exio_pkg::RESP_OKAY});
	endtask
	// expectation is noted before the request; the monitor compares it
	task automatic axr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int t;
		rq.push_back('{d, r});
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && t < 100);
		rready <= 1'b0;
		if (t >= 100) check("rvalid", 32'h0, 32'h1);
	endtask
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			re = rq.pop_front();
			check("rdata", rdata, re.d);
			check("rresp", {30'h0, rresp}, {30'h0, re.r});
		end
	end
	task automatic cfg(input int ch, input logic [4:0] s, input logic p);
		axw(cha(ch, exio_pkg::CH_CFG), {23'h0, p, 3'h0, s});
	endtask
	// bits 0, 5, 7 and 12 are steered; the rest is random noise
	task automatic drv(input logic [31:0] v);
		@(posedge clk);
		sig <= ($random(seed) & ~32'h000010A1) | v;
	endtask
	task automatic want(input string n, input int i, input logic v,
		input int lim);
		int t;
		t = 0;
		while (obs[i] !== v && t < lim) begin
			@(negedge clk);
			t++;
		end
		check(n, {31'h0, obs[i]}, {31'h0, v});
	endtask
	task automatic keep(input string n, input int i, input logic v,
		input int cyc);
		logic ok;
		ok = 1'b1;
		repeat (cyc) begin
			@(negedge clk);
			if (obs[i] !== v) ok = 1'b0;
		end
		check(n, {31'h0, ok}, 32'h1);
	endtask
	task automatic want_ao(input logic [15:0] e);
		int t;
		t = 0;
		while (aout !== e && t < 400) begin
			@(negedge clk);
			t++;
		end
		check("aout2", {16'h0, aout}, {16'h0, e});
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end

	initial begin
		for (c = 0; c < 20; c++) qty[16 * c +: 16] = 16'($random(seed));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		axr(exio_pkg::A_SLOT, 32'h0, exio_pkg::RESP_OKAY);
		axr(exio_pkg::A_AOUT_HI, 32'hFFFF, exio_pkg::RESP_OKAY);
		axr(12'h0FC, 32'h0, exio_pkg::RESP_SLVERR);
		axw(12'h0FC, 32'h5);
		pres <= 3'h1;
		for (c = 0; c < 13; c++) begin
			axw(exio_pkg::A_SLOT, 32'(c));
			repeat (3) @(negedge clk);
			check("hot", 32'(hot), (c >= 1 && c <= 10) ?
				32'h1 << (c - 1) : 32'h0);
			axr(exio_pkg::A_ONLINE, 32'(c >= 1 && c <= 10),
				exio_pkg::RESP_OKAY);
		end
		pres <= 3'h7;
		for (c = 0; c < 3; c++) begin
			axw(exio_pkg::A_SLOT + 12'(4 * c), 32'(c + 1));
			axw(exio_pkg::A_DIR + 12'(4 * c), 32'(c + 1));
		end
		repeat (4) @(negedge clk);
		check("hot", 32'(hot), 32'h00400801);
		check("oe", 32'(boe), 32'h39);
		axr(exio_pkg::A_ONLINE, 32'h7, exio_pkg::RESP_OKAY);
		cfg(0, 5'h05, 1'b0);
		cfg(2, 5'h07, 1'b0);
		drv(32'h20);
		want("out0", 0, 1'b1, 20);
		want("relay", 12, 1'b0, 20);
		drv(32'h80);
		want("out0", 0, 1'b0, 20);
		want("relay", 12, 1'b1, 20);
		cfg(0, 5'h05, 1'b1);
		cfg(2, 5'h07, 1'b1);
		want("out0", 0, 1'b1, 20);
		want("relay", 12, 1'b0, 20);
		cfg(0, 5'h05, 1'b0);
		cfg(1, 5'h00, 1'b1);
		drv(32'h20);
		ext <= 6'h02;
		want("din1", 16, 1'b0, 20);
		axr(exio_pkg::A_PHYS, 32'h03, exio_pkg::RESP_OKAY);
		ext <= 6'h00;
		want("din1", 16, 1'b1, 20);
		// drop out0 before the off-delay exists, or it takes 4 ticks
		drv(32'h0);
		want("out0", 0, 1'b0, 20);
		axw(cha(0, exio_pkg::CH_ON), 32'h2);
		axw(cha(0, exio_pkg::CH_OFF), 32'h4);
		// two ticks on, four off; tick phase is unknown, so bounds are wide
		drv(32'hA0);
		// relay has no delay and inverts, so it falls while out0 waits
		want("relay", 12, 1'b0, 20);
		keep("on_wait", 0, 1'b0, 70);
		want("on_done", 0, 1'b1, 300);
		drv(32'h0);
		keep("off_wait", 0, 1'b1, 290);
		want("off_done", 0, 1'b0, 550);
		@(posedge clk);
		fin <= 2'h1;
		want("fast_in", 21, 1'b1, 20);
		@(posedge clk);
		fin <= 2'h0;
		want("fast_in", 21, 1'b0, 20);
		cfg(11, 5'h0C, 1'b1);
		want("fast_out", 23, 1'b1, 20);
		drv(32'h1000);
		want("fast_out", 23, 1'b0, 20);
		for (c = 0; c < 20; c++) begin
			axw(exio_pkg::A_AOUT_SRC, 32'(c));
			want_ao((c == 14 || c == 15) ? 16'h0000 :
				qty[16 * c +: 16]);
		end
		axw(exio_pkg::A_AOUT_SRC, 32'h0);
		axw(exio_pkg::A_AOUT_LO, 32'h3E8);
		axw(exio_pkg::A_AOUT_LOR, 32'h100);
		axw(exio_pkg::A_AOUT_HI, 32'hBB8);
		axw(exio_pkg::A_AOUT_HIR, 32'h8D0);
		qty[15:0] <= 16'h01F4;
		want_ao(16'h0100);
		qty[15:0] <= 16'h0FA0;
		want_ao(16'h08D0);
		qty[15:0] <= 16'h07D0;
		want_ao(16'h04E8);
		axw(exio_pkg::A_AOUT_FILT, 32'h4);
		qty[15:0] <= 16'h0FA0;
		repeat (150) @(negedge clk);
		check("aout_filt", {31'h0, aout === 16'h08D0}, 32'h0);
		// at least one tick has passed: a 1/16 step, not the full jump
		c = 32'(aout > 16'h04E8 && aout < 16'h08D0);
		check("aout_mid", c, 32'h1);
		stop_test();
	end
endmodule
